// ---- src/wdit_timer.sv ----
// Watchdog / interval timer with set-only control bits
// How it works
// RL1: Low three select bits pick watchdog period
// RL2: Interval mode uses same eight period codes
// RL3: Mode bit one selects watchdog operation
// RL4: Mode bit zero gives repeated interval requests
// RL5: Writing run one clears and restarts count
// RL6: Run bit ignores software writes of zero
// RL7: Action and mode bits are set-only
// RL8: Watchdog overflow gives reset or nonmaskable interrupt
// RL9: Mode set with flag pending forces NMI
// RL10: Software clears request flag before watchdog
// RL11: Software restarts run within every period
// RL12: Counts in HALT, stops in STOP
// RL13: Software restarts count just before STOP
// RL14: Count holds while CPU on subsystem clock
// RL15: Interval request obeys mask and priority flags
// RL16: Interval request has highest default priority
// RL17: Prescaler not cleared, first period shorter
// RL18: Reset loads zero into both registers
// RL19: Clock select written by whole bytes only
// RL20: Stop timer before changing clock select
// RL21: Watchdog and interval modes are exclusive
// RL22: Interval overflow flags, restarts, keeps counting
// RL23: No counting before first run write
`timescale 1ns/1ps
module wdit_timer
  import wdit_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register access
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_byte,
  input wire logic i_wr_bit,
  input wire logic [2:0] i_bit_idx,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Main clock tick (from system clock divider, same domain)
  input wire logic i_main_tick,
  // Standby and clock status
  input wire logic i_stop_mode,
  input wire logic i_subsys_clk,
  // Interrupt flag access
  input wire logic i_wd_flag_clr,
  input wire logic i_wd_flag_set,
  input wire logic i_wd_mask_flag,
  input wire logic i_wd_priority_flag,
  // Outputs
  output logic o_wd_request_flag,
  output logic o_interval_irq,
  output logic o_irq_priority,
  output logic o_irq_top_default,
  output logic o_nmi_req,
  output logic o_sys_reset_req,
  output logic [COUNT_W-1:0] o_count
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] timer_clock_select_two;
  logic run_bit;
  logic overflow_action_select;
  logic mode_select_bit;
  logic [PRESCALE_LOG2-1:0] prescale;
  logic [COUNT_W-1:0] count;
  logic wd_request_flag;
  logic nmi_req;
  logic sys_reset_req;
  logic interval_irq;
  wdit_state_type state;

  logic wr_clk_sel;
  logic wr_mode;
  logic [7:0] mode_wdata;
  logic run_write;
  logic mode_set_now;
  logic count_enable;
  logic count_tick;
  logic overflow;
  logic [4:0] period_log2;
  logic [7:0] mode_value;

  assign mode_value = {run_bit, 2'b00, mode_select_bit,
                       overflow_action_select, 3'b000};

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  always_comb
  begin
    wr_clk_sel = 1'b0;
    wr_mode = 1'b0;
    mode_wdata = 8'h00;
    if (i_addr == CLK_SEL_ADDR)
    begin
      // RL19: byte writes only
      wr_clk_sel = i_wr_byte;
    end
    else if (i_addr == MODE_CTRL_ADDR)
    begin
      wr_mode = i_wr_byte | i_wr_bit;
      if (i_wr_byte)
        mode_wdata = i_wdata;
      else
        mode_wdata = 8'((i_wdata[0] ? 8'h01 : 8'h00) << i_bit_idx);
    end
  end

  assign run_write = wr_mode & mode_wdata[RUN_POS];
  assign mode_set_now = wr_mode & mode_wdata[MODE_SEL_POS]
                        & ~mode_select_bit;

  // ----------------------------------------
  // Clock select register
  // ----------------------------------------
  // RL18: reset to zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      timer_clock_select_two <= CLK_SEL_RESET;
    else if (wr_clk_sel)
      timer_clock_select_two <= i_wdata;
  end

  // ----------------------------------------
  // Mode register, set-only bits
  // ----------------------------------------
  // RL6: run set-only
  // RL7: mode, action set-only
  // RL21: mode bit chooses one function
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      run_bit <= MODE_CTRL_RESET[RUN_POS];
      mode_select_bit <= MODE_CTRL_RESET[MODE_SEL_POS];
      overflow_action_select <= MODE_CTRL_RESET[ACTION_POS];
    end
    else if (wr_mode)
    begin
      run_bit <= run_bit | mode_wdata[RUN_POS];
      mode_select_bit <= mode_select_bit | mode_wdata[MODE_SEL_POS];
      overflow_action_select <= overflow_action_select
                                | mode_wdata[ACTION_POS];
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    o_rdata = 8'h00;
    if (i_rd && i_addr == CLK_SEL_ADDR)
      o_rdata = timer_clock_select_two;
    else if (i_rd && i_addr == MODE_CTRL_ADDR)
      o_rdata = mode_value;
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  // RL12: stop only in STOP
  // RL14: hold on subsystem clock
  // RL23: idle until first run
  assign count_enable = (state == WDIT_RUN) & ~i_stop_mode
                        & ~i_subsys_clk & i_main_tick;

  // RL17: prescaler free, never cleared by run
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      prescale <= '0;
    else if (count_enable)
      prescale <= prescale + 1'b1;
  end

  assign count_tick = count_enable & (&prescale);

  // RL1: period select decode
  // RL2: same codes in interval mode
  always_comb
  begin
    if (timer_clock_select_two[PERIOD_LSB +: PERIOD_W] == 3'h7)
      period_log2 = 5'(PERIOD_MAX_LOG2 - PRESCALE_LOG2);
    else
      period_log2 = 5'(PERIOD_MIN_LOG2 - PRESCALE_LOG2)
                    + 5'(timer_clock_select_two[PERIOD_LSB +: PERIOD_W]);
  end

  assign overflow = count_tick
                    & (count == COUNT_W'((32'h1 << period_log2) - 1));

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      state <= WDIT_IDLE;
    else if (run_write)
      state <= WDIT_RUN;
  end

  // RL5: run write clears count
  // RL22: interval overflow wraps to zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      count <= '0;
    else if (run_write)
      count <= '0;
    else if (overflow)
      count <= '0;
    else if (count_tick)
      count <= count + 1'b1;
  end

  // ----------------------------------------
  // Request flag, set wins over clear
  // ----------------------------------------
  // RL4: interval overflow sets flag
  // RL22: one flag per overflow
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      wd_request_flag <= 1'b0;
    else if ((overflow & ~mode_select_bit) | i_wd_flag_set)
      wd_request_flag <= 1'b1;
    else if (i_wd_flag_clr)
      wd_request_flag <= 1'b0;
  end

  // ----------------------------------------
  // Interrupt and reset requests
  // ----------------------------------------
  // RL15: mask applies in interval mode
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      interval_irq <= 1'b0;
    else
      interval_irq <= wd_request_flag & ~i_wd_mask_flag
                      & ~mode_select_bit;
  end

  // RL3: watchdog overflow actions
  // RL8: action bit picks reset or NMI
  // RL9: pending flag forces NMI
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      nmi_req <= 1'b0;
      sys_reset_req <= 1'b0;
    end
    else
    begin
      nmi_req <= (overflow & mode_select_bit & ~overflow_action_select)
                 | (mode_set_now & wd_request_flag);
      sys_reset_req <= overflow & mode_select_bit & overflow_action_select;
    end
  end

  assign o_wd_request_flag = wd_request_flag;
  assign o_interval_irq = interval_irq;
  assign o_irq_priority = i_wd_priority_flag & ~mode_select_bit;
  // RL16: highest default priority
  assign o_irq_top_default = interval_irq;
  assign o_nmi_req = nmi_req;
  assign o_sys_reset_req = sys_reset_req;
  assign o_count = count;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_run_sticky;
    @(posedge i_clk_sys) disable iff (i_rst)
    run_bit |=> run_bit;
  endproperty
  a_run_sticky: assert property (p_run_sticky) // RL6
    else $error("run bit cleared");

  property p_mode_sticky;
    @(posedge i_clk_sys) disable iff (i_rst)
    mode_select_bit |=> mode_select_bit && $stable(mode_select_bit);
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) // RL7
    else $error("mode bit cleared");

  property p_run_clears;
    @(posedge i_clk_sys) disable iff (i_rst)
    run_write |=> count == '0;
  endproperty
  a_run_clears: assert property (p_run_clears) // RL5
    else $error("count not cleared by run");

  property p_idle_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
    (state == WDIT_IDLE && !run_write) |=> count == '0;
  endproperty
  a_idle_hold: assert property (p_idle_hold) // RL23
    else $error("count moved before run");

  property p_stop_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_stop_mode || i_subsys_clk) && !run_write |=> $stable(count);
  endproperty
  a_stop_hold: assert property (p_stop_hold) // RL14
    else $error("count moved while stopped");

  property p_wd_action;
    @(posedge i_clk_sys) disable iff (i_rst)
    overflow && mode_select_bit |=>
      (sys_reset_req == $past(overflow_action_select))
      && (nmi_req || sys_reset_req);
  endproperty
  a_wd_action: assert property (p_wd_action) // RL8
    else $error("wrong watchdog action");

  property p_forced_nmi;
    @(posedge i_clk_sys) disable iff (i_rst)
    mode_set_now && wd_request_flag |=> nmi_req;
  endproperty
  a_forced_nmi: assert property (p_forced_nmi) // RL9
    else $error("forced nmi missing");

  property p_interval_flag;
    @(posedge i_clk_sys) disable iff (i_rst)
    overflow && !mode_select_bit |=> wd_request_flag && count == '0;
  endproperty
  a_interval_flag: assert property (p_interval_flag) // RL22
    else $error("interval overflow not flagged");

  property p_exclusive;
    @(posedge i_clk_sys) disable iff (i_rst)
    mode_select_bit |=> !interval_irq;
  endproperty
  a_exclusive: assert property (p_exclusive) // RL21
    else $error("interval irq in watchdog mode");

endmodule

// ---- src/wdit_pkg.sv ----
// Constants for the watchdog / interval timer block
package wdit_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [15:0] CLK_SEL_ADDR = 16'hff42;
  localparam logic [15:0] MODE_CTRL_ADDR = 16'hff49;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RUN_POS = 7;
  localparam int MODE_SEL_POS = 4;
  localparam int ACTION_POS = 3;
  localparam int PERIOD_LSB = 0;
  localparam int PERIOD_W = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int PRESCALE_LOG2 = 4;
  localparam int COUNT_W = 16;
  localparam int PERIOD_MIN_LOG2 = 12;
  localparam int PERIOD_MAX_LOG2 = 20;

  // Counter state
  typedef enum logic [1:0]
  {
    WDIT_IDLE = 2'b00,
    WDIT_RUN = 2'b01
  } wdit_state_type;

endpackage

// ---- bench/wdit_host.sv ----
// Host model: main clock source and request receivers
`timescale 1ns/1ps
module wdit_host
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Device requests
  input wire logic i_nmi_req,
  input wire logic i_sys_reset_req,
  // Tick and tallies
  output logic o_main_tick,
  output logic [7:0] o_nmi_cnt,
  output logic [7:0] o_rst_cnt
);
  // Full-rate tick keeps the long periods short in cycles
  always_ff @(posedge i_clk_sys)
    o_main_tick <= !i_rst;

  always_ff @(posedge i_clk_sys)
    if (i_rst)
    begin
      o_nmi_cnt <= 8'h00;
      o_rst_cnt <= 8'h00;
    end
    else
    begin
      o_nmi_cnt <= o_nmi_cnt + {7'h00, i_nmi_req};
      o_rst_cnt <= o_rst_cnt + {7'h00, i_sys_reset_req};
    end
endmodule

// ---- bench/wdit_timer_test.sv ----
// Self-checking bench for the watchdog / interval timer
`timescale 1ns/1ps
module wdit_timer_test
  import wdit_pkg::*;
;
  typedef struct packed
  {
    logic [2:0] code;
    logic mask;
    logic prio;
    logic irq;
    logic pri;
  } wdit_row_type;

  logic clk, rst, we, rd, fclr, fset, mask, prio, stop, sub, wb;
  logic [2:0] bidx;
  logic [15:0] addr;
  logic [7:0] wd, rdata, ncnt, rcnt;
  logic flag, irq, pri, top, nmi, srst, tick;
  logic [COUNT_W-1:0] count, c;
  logic [7:0] nc [2];
  int fails, n_checks, cyc, n, per;
  wdit_row_type rows [3] = '{'{3'h0, 1'h0, 1'h1, 1'h1, 1'h1},
    '{3'h1, 1'h1, 1'h0, 1'h0, 1'h0}, '{3'h2, 1'h0, 1'h0, 1'h1, 1'h0}};

  wdit_timer dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wd), .i_wr_byte(we), .i_wr_bit(wb), .i_bit_idx(bidx),
    .i_rd(rd), .o_rdata(rdata), .i_main_tick(tick), .i_stop_mode(stop),
    .i_subsys_clk(sub), .i_wd_flag_clr(fclr), .i_wd_flag_set(fset),
    .i_wd_mask_flag(mask), .i_wd_priority_flag(prio),
    .o_wd_request_flag(flag), .o_interval_irq(irq), .o_irq_priority(pri),
    .o_irq_top_default(top), .o_nmi_req(nmi), .o_sys_reset_req(srst),
    .o_count(count));
  wdit_host host (.i_clk_sys(clk), .i_rst(rst), .i_nmi_req(nmi),
    .i_sys_reset_req(srst), .o_main_tick(tick), .o_nmi_cnt(ncnt),
    .o_rst_cnt(rcnt));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask

  // Single-bit write, value one, at bit index b
  task automatic wrb(input logic [15:0] a, input logic [2:0] b);
    @(posedge clk);
    addr <= a;
    wd <= 8'h01;
    bidx <= b;
    wb <= 1'b1;
    @(posedge clk);
    wb <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    cyc_n(1);
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask

  // Pulse one of the flag strobes for a single cycle
  task automatic fpulse(input logic s);
    @(posedge clk);
    fset <= s;
    fclr <= !s;
    @(posedge clk);
    fset <= 1'b0;
    fclr <= 1'b0;
    #1;
  endtask

  task automatic wait_hi(input logic s, input int lim);
    n = 0;
    while (n < lim && (s ? (nmi | srst) : flag) !== 1'b1)
    begin
      cyc_n(1);
      n++;
    end
  endtask

  task automatic do_rst;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run needs about 74k cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      fails++;
      summarize();
    end
  end

  initial
  begin
    {rst, we, rd, fclr, fset, mask, prio, stop, sub} = 9'h140;
    wb = 1'b0;
    bidx = 3'h0;
    addr = 16'h0000;
    wd = 8'h00;
    do_rst();
    cyc_n(40);
    rd_chk(CLK_SEL_ADDR, 8'h00);
    rd_chk(MODE_CTRL_ADDR, 8'h00);
    chk("idle count", 16'h0000, count);
    foreach (rows[i])
    begin
      do_rst();
      @(posedge clk);
      mask <= rows[i].mask;
      prio <= rows[i].prio;
      per = 1 << (PERIOD_MIN_LOG2 + rows[i].code);
      wr(CLK_SEL_ADDR, {5'h00, rows[i].code});
      wr(MODE_CTRL_ADDR, 8'h80);
      wait_hi(1'b0, per + 20);
      chk("first period", 1, n >= per - 16 && n <= per + 3);
      // Request output is registered one cycle behind the flag
      cyc_n(1);
      chk("interval irq", rows[i].irq, irq);
      chk("top default", rows[i].irq, top);
      chk("priority", rows[i].pri, pri);
      fpulse(1'b0);
      wait_hi(1'b0, per + 20);
      chk("next period", 1, n >= per - 4 && n <= per);
    end
    for (int a = 0; a < 2; a++)
    begin
      do_rst();
      fpulse(1'b0);
      wr(CLK_SEL_ADDR, 8'h00);
      wr(MODE_CTRL_ADDR, {4'h9, a[0], 3'h0});
      repeat (2)
      begin
        cyc_n(2000);
        wr(MODE_CTRL_ADDR, 8'h80);
      end
      wait_hi(1'b1, 4200);
      cyc_n(2);
      nc[a] = ncnt;
      chk("overflow pulses", 1, ncnt + rcnt);
      chk("no interval irq", 0, irq);
      wr(MODE_CTRL_ADDR, 8'h00);
      rd_chk(MODE_CTRL_ADDR, {4'h9, a[0], 3'h0});
    end
    chk("action choice", 1, nc[0] != nc[1]);
    do_rst();
    fpulse(1'b1);
    wr(MODE_CTRL_ADDR, 8'h18);
    cyc_n(3);
    chk("forced nmi", 1, ncnt);
    do_rst();
    wr(CLK_SEL_ADDR, 8'h07);
    for (int k = 0; k < 2; k++)
    begin
      wr(MODE_CTRL_ADDR, 8'h80);
      chk("restart", 0, count);
      cyc_n(64);
      @(posedge clk);
      stop <= (k == 0);
      sub <= (k == 1);
      cyc_n(2);
      c = count;
      cyc_n(64);
      chk("frozen", c, count);
      @(posedge clk);
      stop <= 1'b0;
      sub <= 1'b0;
      cyc_n(64);
      chk("resumed", 1, count != c);
    end
    do_rst();
    wrb(CLK_SEL_ADDR, 3'h2);
    wrb(MODE_CTRL_ADDR, 3'h7);
    rd_chk(CLK_SEL_ADDR, 8'h00);
    rd_chk(MODE_CTRL_ADDR, 8'h80);
    summarize();
  end
endmodule
